// ==== src/uaar_pkg.sv ====
// constants, register map and types of the receive address recognition block
//
// Notes on behaviour
// - two mode bits in the control register pick one of four serial modes.
// - address filtering works in modes 1, 2 and 3 when filter enabled.
// - in modes 1, 2 and 3 with filter on, receive flag sets only on group or broadcast address match.
// - mode 1: stop bit replaces ninth bit; needs address match and valid stop.
// - mode 0 ignores the filter enable bit completely.
// - group address: mask zero bits are don't-care, mask one bits must equal address.
// - broadcast is address OR mask; its one bits must be received as one.
// - reset clears own address and mask, so every address matches.
package uaar_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_OWN_ADDR = 4'h1;
	localparam logic [ADDR_W-1:0] REG_DONT_CARE = 4'h2;
	localparam logic [ADDR_W-1:0] REG_RX_DATA = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;
	localparam logic [ADDR_W-1:0] REG_REJECTS = 4'h6;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_HI = 7;
	localparam int CTRL_MODE_LO = 6;
	localparam int CTRL_FILTER_EN = 5;
	localparam int CTRL_RX_ENABLE = 4;
	localparam int CTRL_NINTH_BIT = 2;
	localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 8'hf0;

	// ----------------------------------------------------------------
	// status and interrupt fields, same layout for the mask
	// ----------------------------------------------------------------
	localparam int ST_RX_COMPLETE = 0;
	localparam int ST_FRAME_ERROR = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_REJECTED = 3;
	localparam int ST_W = 4;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
	localparam logic [DATA_W-1:0] RST_OWN_ADDR = 8'h00;
	localparam logic [DATA_W-1:0] RST_DONT_CARE = 8'h00;
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [ST_W-1:0] RST_STATUS = 4'h0;
	localparam logic [DATA_W-1:0] REJECT_MAX = 8'hff;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] BIT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// serial modes and receiver states
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_9BIT_FIXED = 2'h2;
	localparam logic [1:0] MODE_9BIT_VAR = 2'h3;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_DATA,
		RX_NINTH,
		RX_STOP
	} uaar_rxstate_t;

endpackage

// ==== src/uaar_addr_match.sv ====
// address comparator: group select and broadcast hits for one received byte
`timescale 1ns/10ps
module uaar_addr_match
	import uaar_pkg::*;
(
	input wire logic [DATA_W-1:0] ownAddr,
	input wire logic [DATA_W-1:0] dontCareMask,
	input wire logic [DATA_W-1:0] rxByte,
	output logic groupHit,
	output logic broadcastHit
);

	logic [DATA_W-1:0] broadcastAddr;

	// ----------------------------------------------------------------
	// group select
	// ----------------------------------------------------------------
	// only bits with a mask one must agree with the own address
	assign groupHit = ((rxByte ^ ownAddr) & dontCareMask) == RST_BYTE;

	// ----------------------------------------------------------------
	// broadcast
	// ----------------------------------------------------------------
	assign broadcastAddr = ownAddr | dontCareMask;
	// every one in the broadcast pattern must arrive as one
	assign broadcastHit = (rxByte & broadcastAddr) == broadcastAddr;

endmodule

// ==== src/uaar_receiver.sv ====
// serial receiver with automatic address recognition and register port
`timescale 1ns/10ps
module uaar_receiver
	import uaar_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdData,
	input wire logic rxdPin,
	input wire logic rxTick,
	output logic rxAccept,
	output logic irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] control;
	logic [DATA_W-1:0] ownAddr;
	logic [DATA_W-1:0] dontCareMask;
	logic [DATA_W-1:0] rxData;
	logic [DATA_W-1:0] rejectCount;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] irqMask;
	logic [ST_W-1:0] next_status;
	logic [ST_W-1:0] statusSet;
	logic [ST_W-1:0] statusClear;
	logic rxNinthBit;
	logic syncA;
	logic syncB;
	logic syncC;
	logic rxdLevel;
	uaar_rxstate_t rxState;
	logic [3:0] bitCount;
	logic [DATA_W-1:0] shiftReg;
	logic ninthSample;
	logic frameDone;
	logic frameStop;
	logic frameNinth;
	logic [1:0] mode;
	logic filterEn;
	logic rxEnable;
	logic groupHit;
	logic broadcastHit;
	logic addrHit;
	logic filterActive;
	logic frameAccept;
	logic framePass;
	logic writeHit;
	logic startShift;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// one write decode for every register keeps the strobe test alike
	function automatic logic busWrite(input logic strobe, input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target);
		return strobe && (addr == target);
	endfunction

	function automatic logic isShiftMode(input logic [1:0] m);
		return m == MODE_SHIFT;
	endfunction

	// lsb-first shift, used by the shifter and by the early byte view
	function automatic logic [DATA_W-1:0] shiftIn(input logic lineBit,
		input logic [DATA_W-1:0] sr);
		return {lineBit, sr[DATA_W-1:1]};
	endfunction

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	assign mode = {control[CTRL_MODE_HI], control[CTRL_MODE_LO]};
	assign filterEn = control[CTRL_FILTER_EN];
	assign rxEnable = control[CTRL_RX_ENABLE];

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	// third stage filters a single sampled glitch on the line
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			syncA <= 1'b1;
			syncB <= 1'b1;
			syncC <= 1'b1;
		end else begin
			syncA <= rxdPin;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rxdLevel <= 1'b1;
		end else if (syncB == syncC) begin
			rxdLevel <= syncC;
		end
	end

	// ----------------------------------------------------------------
	// frame receiver
	// ----------------------------------------------------------------
	// shift mode only starts once software has emptied the flag
	assign startShift = isShiftMode(mode) && rxEnable && !status[ST_RX_COMPLETE];

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rxState <= RX_IDLE;
			bitCount <= BIT_RESET;
			shiftReg <= RST_BYTE;
			ninthSample <= 1'b0;
		end else begin
			unique case (rxState)
				RX_IDLE: begin
					bitCount <= BIT_RESET;
					if (startShift) begin
						rxState <= RX_DATA;
					end else if (rxTick && rxEnable && !isShiftMode(mode) && !rxdLevel) begin
						rxState <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (!rxEnable) begin
						rxState <= RX_IDLE;
					end else if (rxTick) begin
						// least significant bit arrives first
						shiftReg <= shiftIn(rxdLevel, shiftReg);
						bitCount <= bitCount + 4'h1;
						if (bitCount == LAST_DATA_BIT) begin
							if (isShiftMode(mode)) begin
								rxState <= RX_IDLE;
							end else if (mode == MODE_8BIT) begin
								rxState <= RX_STOP;
							end else begin
								rxState <= RX_NINTH;
							end
						end
					end
				end
				RX_NINTH: begin
					if (!rxEnable) begin
						rxState <= RX_IDLE;
					end else if (rxTick) begin
						ninthSample <= rxdLevel;
						rxState <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (!rxEnable) begin
						rxState <= RX_IDLE;
					end else if (rxTick) begin
						rxState <= RX_IDLE;
					end
				end
				// codes beyond the four states fall back to idle
				default: begin
					rxState <= RX_IDLE;
				end
			endcase
		end
	end

	// frame end pulse, with the stop or last data sample still on the line
	always_comb begin
		frameDone = 1'b0;
		frameStop = 1'b1;
		frameNinth = ninthSample;
		if (rxEnable && rxTick) begin
			if (rxState == RX_STOP) begin
				frameDone = 1'b1;
				frameStop = rxdLevel;
			end else if ((rxState == RX_DATA) && isShiftMode(mode)
				&& (bitCount == LAST_DATA_BIT)) begin
				frameDone = 1'b1;
			end
		end
		if (mode == MODE_8BIT) begin
			frameNinth = frameStop;
		end
	end

	// the byte seen at frame end includes the bit shifted in this cycle
	logic [DATA_W-1:0] frameByte;
	assign frameByte = isShiftMode(mode) ? shiftIn(rxdLevel, shiftReg) : shiftReg;

	// ----------------------------------------------------------------
	// address recognition
	// ----------------------------------------------------------------
	uaar_addr_match uaar_addr_match_i (
		.ownAddr(ownAddr),
		.dontCareMask(dontCareMask),
		.rxByte(frameByte),
		.groupHit(groupHit),
		.broadcastHit(broadcastHit)
	);

	assign addrHit = groupHit || broadcastHit;
	// data frames of a selected slave need the filter cleared by software
	assign filterActive = filterEn && !isShiftMode(mode);

	always_comb begin
		framePass = 1'b1;
		if (filterActive) begin
			if (mode == MODE_8BIT) begin
				framePass = addrHit && frameStop;
			end else begin
				// only frames flagged as address by the ninth bit are looked at
				framePass = addrHit && frameNinth;
			end
		end
	end

	// a pending flag blocks a new byte: unread data must not be overwritten
	assign frameAccept = frameDone && framePass && !status[ST_RX_COMPLETE];

	// ----------------------------------------------------------------
	// received data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rxData <= RST_BYTE;
			rxNinthBit <= 1'b0;
		end else if (frameAccept) begin
			rxData <= frameByte;
			rxNinthBit <= frameNinth;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rxAccept <= 1'b0;
		end else begin
			rxAccept <= frameAccept;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rejectCount <= RST_BYTE;
		end else if (frameDone && !framePass && (rejectCount != REJECT_MAX)) begin
			rejectCount <= rejectCount + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	assign writeHit = busWrite(regWrite, regAddr, REG_STATUS);

	always_comb begin
		statusSet = RST_STATUS;
		statusSet[ST_RX_COMPLETE] = frameAccept;
		statusSet[ST_FRAME_ERROR] = frameDone && !isShiftMode(mode) && !frameStop;
		statusSet[ST_OVERRUN] = frameDone && framePass && status[ST_RX_COMPLETE];
		statusSet[ST_REJECTED] = frameDone && !framePass;
		statusClear = writeHit ? regWrData[ST_W-1:0] : RST_STATUS;
		// a new event beats a clear in the same cycle
		next_status = (status & ~statusClear) | statusSet;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			status <= RST_STATUS;
		end else begin
			status <= next_status;
		end
	end

	assign irq = |(status & irqMask);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			control <= RST_CONTROL;
		end else if (busWrite(regWrite, regAddr, REG_CONTROL)) begin
			control <= regWrData & CTRL_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ownAddr <= RST_OWN_ADDR;
		end else if (busWrite(regWrite, regAddr, REG_OWN_ADDR)) begin
			ownAddr <= regWrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dontCareMask <= RST_DONT_CARE;
		end else if (busWrite(regWrite, regAddr, REG_DONT_CARE)) begin
			dontCareMask <= regWrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irqMask <= RST_STATUS;
		end else if (busWrite(regWrite, regAddr, REG_IRQ_MASK)) begin
			irqMask <= regWrData[ST_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] next_rdData;

	always_comb begin
		next_rdData = RST_BYTE;
		unique case (regAddr)
			REG_CONTROL: begin
				next_rdData = control;
				next_rdData[CTRL_NINTH_BIT] = rxNinthBit;
			end
			REG_OWN_ADDR: next_rdData = ownAddr;
			REG_DONT_CARE: next_rdData = dontCareMask;
			REG_RX_DATA: next_rdData = rxData;
			REG_STATUS: next_rdData[ST_W-1:0] = status;
			REG_IRQ_MASK: next_rdData[ST_W-1:0] = irqMask;
			REG_REJECTS: next_rdData = rejectCount;
			default: next_rdData = RST_BYTE;
		endcase
	end

	// data only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			regRdData <= RST_BYTE;
		end else if (regRead) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= RST_BYTE;
		end
	end

endmodule

// ==== tb/uaar_receiver_monitor.sv ====
// port checker for the address recognition receiver
`timescale 1ns/10ps
module uaar_receiver_monitor
	import uaar_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic rxdPin,
	input wire logic rxTick,
	input wire logic rxAccept,
	input wire logic irq
);
	logic [7:0] own, msk, ctl, rxb;
	logic [9:0] hist;
	logic filt, hit;
	// ----
	// shadow registers and line history
	// ----
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			own <= 8'h00;
			msk <= 8'h00;
			ctl <= 8'h00;
		end else if (regWrite) begin
			if (regAddr == REG_OWN_ADDR) own <= regWrData;
			if (regAddr == REG_DONT_CARE) msk <= regWrData;
			if (regAddr == REG_CONTROL) ctl <= regWrData & CTRL_WRITE_MASK;
		end
	end
	// raw pin at the tick; fine only while the line settles well before it
	always_ff @(posedge clk_sys) begin
		if (rxTick) hist <= {hist[8:0], rxdPin};
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			rxb[i] = ctl[CTRL_MODE_HI] ? hist[9-i] : hist[8-i];
		end
	end
	assign filt = ctl[CTRL_FILTER_EN] && ctl[7:6] != MODE_SHIFT;
	assign hit = ((rxb ^ own) & msk) == 8'h00 || (rxb & (own | msk)) == (own | msk);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	chk_own_readback: assert property ($past(regRead) && $past(regAddr) == REG_OWN_ADDR
		|-> regRdData == $past(own)) else $error("own address readback");
	chk_mask_readback: assert property ($past(regRead) && $past(regAddr) == REG_DONT_CARE
		|-> regRdData == $past(msk)) else $error("mask readback");
	chk_ctrl_readback: assert property ($past(regRead) && $past(regAddr) == REG_CONTROL
		|-> regRdData[7:4] == $past(ctl[7:4]) && regRdData[1:0] == 2'h0 && !regRdData[3])
		else $error("control readback");
	chk_accept_pulse: assert property (rxAccept |=> !rxAccept) else $error("accept too long");
	chk_accept_tick: assert property (rxAccept |-> $past(rxTick) || $past(rxTick, 2)
		|| $past(rxTick, 3)) else $error("accept without frame end");
	chk_ninth_set: assert property (rxAccept && filt && ctl[7] |-> hist[1])
		else $error("data frame passed filter");
	chk_stop_valid: assert property (rxAccept && filt && ctl[7:6] == MODE_8BIT |-> hist[0])
		else $error("bad stop passed filter");
	chk_address_hit: assert property (rxAccept && filt |-> hit)
		else $error("address miss accepted");
	cover property (rxAccept && filt);
	cover property (rxAccept && !ctl[CTRL_FILTER_EN]);
	cover property (rxAccept && ctl[7:6] == MODE_SHIFT);
endmodule

bind uaar_receiver uaar_receiver_monitor uaar_receiver_monitor_i (.clk_sys, .resetn, .regAddr,
	.regWrData, .regWrite, .regRead, .regRdData, .rxdPin, .rxTick, .rxAccept, .irq);

// ==== tb/uaar_line_master.sv ====
// multidrop line master model: serial frames and bit ticks
`timescale 1ns/10ps
module uaar_line_master (
	input wire logic clk_sys,
	output logic rxdPin,
	output logic rxTick
);
	logic [2:0] div = 3'h0;
	initial rxdPin = 1'b1;
	// ----
	// bit strobe every eight clocks, longer than the pin sync delay
	// ----
	always @(posedge clk_sys) begin
		div <= div + 3'h1;
	end
	assign rxTick = div == 3'h7;
	task automatic lineLevel(input logic v);
		rxdPin <= v;
	endtask
	task automatic sendFrame(input logic [7:0] b, input logic ninth, input logic sb, input logic nb);
		logic [9:0] bits;
		int n;
		bits = nb ? {sb, ninth, b} : {1'b1, sb, b};
		n = nb ? 10 : 9;
		@(posedge clk_sys iff rxTick);
		rxdPin <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys iff rxTick);
			rxdPin <= bits[i];
		end
		@(posedge clk_sys iff rxTick);
		rxdPin <= 1'b1;
	endtask
endmodule

// ==== tb/uart_address_recognition_bench.sv ====
// self-checking bench for the address recognition receiver
`timescale 1ns/10ps
module uart_address_recognition_bench;
	import uaar_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [DATA_W-1:0] regRdData;
	logic rxdPin, rxTick, rxAccept, irq;
	int failures = 0;
	int samplesChecked = 0;
	int cycles = 0;
	uaar_receiver uaar_receiver_i (.clk_sys, .resetn, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .rxdPin, .rxTick, .rxAccept, .irq);
	uaar_line_master uaar_line_master_i (.clk_sys, .rxdPin, .rxTick);
	always #2 clk_sys = ~clk_sys;
	// ----
	// bus tasks and checks
	// ----
	task automatic finish_test;
		if (failures == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 v = regRdData;
		@(posedge clk_sys);
	endtask
	// one frame: expectation from mode, filter, address fields and trailing bits
	task automatic runCase(input logic [1:0] md, input logic f, input logic [7:0] ow,
		input logic [7:0] mk, input logic [7:0] b, input logic nb, input logic sb);
		logic pass;
		logic [7:0] v;
		pass = !f || (md[1] ? nb : sb) && (((b ^ ow) & mk) == 8'h00 || (b & (ow | mk)) == (ow | mk));
		wr(REG_OWN_ADDR, ow);
		wr(REG_DONT_CARE, mk);
		wr(REG_CONTROL, {md, f, 1'b1, 4'h0});
		uaar_line_master_i.sendFrame(b, nb, sb, md[1]);
		repeat (4) @(posedge clk_sys);
		#1 chk("irq", {7'h0, pass}, {7'h0, irq});
		@(posedge clk_sys);
		rd(REG_STATUS, v);
		chk("status", {4'h0, !pass, 1'b0, !sb, pass}, v & 8'h0b);
		rd(REG_RX_DATA, v);
		if (pass) chk("byte", b, v);
		rd(REG_CONTROL, v);
		if (pass) chk("ninth", {5'h0, (md[1] ? nb : sb), 2'h0}, v & 8'h04);
		wr(REG_STATUS, 8'h0f);
		rd(REG_STATUS, v);
		chk("cleared", 8'h00, v);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		logic [7:0] v;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rd(REG_OWN_ADDR, v);
		chk("own", 8'h00, v);
		rd(REG_DONT_CARE, v);
		chk("mask", 8'h00, v);
		rd(4'h7, v);
		chk("unmapped", 8'h00, v);
		wr(REG_IRQ_MASK, 8'h01);
		runCase(MODE_9BIT_FIXED, 1'b1, 8'h00, 8'h00, 8'h5a, 1'b1, 1'b1);
		runCase(MODE_9BIT_FIXED, 1'b1, 8'hf1, 8'hfa, 8'hf0, 1'b1, 1'b1);
		runCase(MODE_9BIT_FIXED, 1'b1, 8'hf1, 8'hfa, 8'hf2, 1'b1, 1'b1);
		runCase(MODE_9BIT_VAR, 1'b1, 8'hf1, 8'hfa, 8'hfb, 1'b1, 1'b1);
		runCase(MODE_9BIT_VAR, 1'b1, 8'hf1, 8'hfa, 8'hf0, 1'b0, 1'b1);
		runCase(MODE_9BIT_VAR, 1'b0, 8'hf1, 8'hfa, 8'h12, 1'b0, 1'b1);
		runCase(MODE_8BIT, 1'b1, 8'hf1, 8'hfa, 8'hf4, 1'b1, 1'b1);
		runCase(MODE_8BIT, 1'b1, 8'hf1, 8'hfa, 8'hf4, 1'b1, 1'b0);
		runCase(MODE_8BIT, 1'b0, 8'hf1, 8'hfa, 8'h33, 1'b1, 1'b0);
		rd(REG_REJECTS, v);
		chk("rejects", 8'h03, v);
		// shift mode: a low line gives a byte the filter would refuse
		wr(REG_CONTROL, 8'h00);
		uaar_line_master_i.lineLevel(1'b0);
		wr(REG_OWN_ADDR, 8'h55);
		wr(REG_DONT_CARE, 8'hff);
		wr(REG_CONTROL, {MODE_SHIFT, 1'b1, 1'b1, 4'h0});
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk_sys);
		rd(REG_STATUS, v);
		chk("shift status", 8'h01, v & 8'h09);
		rd(REG_RX_DATA, v);
		chk("shift byte", 8'h00, v);
		wr(REG_CONTROL, 8'h00);
		uaar_line_master_i.lineLevel(1'b1);
		finish_test();
	end
endmodule
